// File: dv/dbsc_ctrl_model.sv
// memory controller model driving commands and late write data
`timescale 1ns/1ns
module dbsc_ctrl_model (
  input wire logic clk,
  output logic load_select_n,
  output logic rw_select,
  output logic [dbsc_pkg::ADDR_W-1:0] addr,
  output dbsc_pkg::dbsc_beats_t dq,
  output dbsc_pkg::dbsc_lanes_t byte_enable_n
);
  dbsc_pkg::dbsc_beats_t pend_d;
  dbsc_pkg::dbsc_lanes_t pend_en;

  // idle pins start defined so nothing is taken before the first call
  initial begin
    load_select_n = 1'b1;
    rw_select = 1'b1;
    addr = '0;
    dq = '0;
    byte_enable_n = '1;
    pend_d = '0;
    pend_en = '1;
  end

  // one command per call; address rides on the load select edge
  task automatic issue(input logic rw,
                       input logic [dbsc_pkg::ADDR_W-1:0] a,
                       input dbsc_pkg::dbsc_beats_t d,
                       input dbsc_pkg::dbsc_lanes_t en);
    load_select_n <= 1'b0;
    rw_select <= rw;
    addr <= a;
    dq <= pend_d;
    byte_enable_n <= pend_en;
    @(posedge clk);
    // data of a write follow one cycle behind its command
    pend_d = rw ? ~pend_d : d;
    pend_en = rw ? 8'hFF : en;
  endtask : issue

  // no operation; released lines keep changing so stale data never match
  task automatic idle;
    load_select_n <= 1'b1;
    rw_select <= ~rw_select;
    addr <= ~addr;
    dq <= pend_d;
    byte_enable_n <= pend_en;
    @(posedge clk);
    pend_d = ~pend_d;
    pend_en = '1;
  endtask : idle
endmodule : dbsc_ctrl_model

// File: dv/dbsc_port_test.sv
// self-checking bench of the burst-of-two command port
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module dbsc_port_test;
  localparam logic [35:0] D0 = 36'h123456789;
  localparam logic [35:0] D1 = 36'hABCDEF012;
  localparam logic [35:0] E0 = 36'h0F0F0F0F0;
  localparam logic [35:0] E1 = 36'h3C3C3C3C3;
  logic clock;
  logic clk_run;
  logic rst;
  logic dll_disable_n;
  logic load_select_n;
  logic rw_select;
  logic [dbsc_pkg::ADDR_W-1:0] addr;
  dbsc_pkg::dbsc_beats_t dq_in;
  dbsc_pkg::dbsc_lanes_t byte_enable_n;
  dbsc_pkg::dbsc_beats_t dq_out;
  logic dq_oe;
  logic write_ready;
  int errors = 0;
  int compares = 0;

  dbsc_port i_dbsc_port (
    .CLOCK(clock), .RST(rst), .LOAD_SELECT_N(load_select_n),
    .RW_SELECT(rw_select), .ADDR(addr), .DQ_IN(dq_in),
    .BYTE_ENABLE_N(byte_enable_n), .DLL_DISABLE_N(dll_disable_n),
    .DQ_OUT(dq_out), .DQ_OE(dq_oe), .WRITE_READY(write_ready)
  );

  dbsc_ctrl_model i_dbsc_ctrl_model (
    .clk(clock), .load_select_n(load_select_n), .rw_select(rw_select),
    .addr(addr), .dq(dq_in), .byte_enable_n(byte_enable_n)
  );

  // gated clock so the stop-clock case can freeze it
  initial begin
    clock = 1'b0;
    forever #5 if (clk_run) clock = ~clock;
  end

  task automatic wrap_up;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // look once the edge has landed, then spend that cycle
  task automatic chk_q(input logic oe, input dbsc_pkg::dbsc_beats_t q);
    #1;
    `CHK(dq_oe, oe)
    if (oe) `CHK(dq_out, q)
    @(posedge clock);
  endtask : chk_q

  // a spare idle lets the write buffer drain before later reads
  task automatic wr(input logic [18:0] a, input dbsc_pkg::dbsc_beats_t d,
                    input dbsc_pkg::dbsc_lanes_t en);
    i_dbsc_ctrl_model.issue(1'b0, a, d, en);
    i_dbsc_ctrl_model.idle();
    i_dbsc_ctrl_model.idle();
  endtask : wr

  task automatic rd(input logic [18:0] a, input dbsc_pkg::dbsc_beats_t q);
    i_dbsc_ctrl_model.issue(1'b1, a, '0, '1);
    i_dbsc_ctrl_model.idle();
    i_dbsc_ctrl_model.idle();
    chk_q(1'b1, q);
    chk_q(1'b0, q);
  endtask : rd

  // wrapping burst address, coherent reads, back-to-back read commands
  task automatic s_burst;
    wr(19'h00013, {D1, D0}, '0);
    wr(19'h00011, {E1, E0}, '0);
    i_dbsc_ctrl_model.issue(1'b1, 19'h00010, '0, '1);
    i_dbsc_ctrl_model.issue(1'b1, 19'h00013, '0, '1);
    i_dbsc_ctrl_model.idle();
    chk_q(1'b1, {E0, D1});
    chk_q(1'b1, {D1, D0});
    chk_q(1'b0, '0);
  endtask : s_burst

  // each lane enable gates its own nine bits; all high aborts the beat
  task automatic s_lanes;
    dbsc_pkg::dbsc_lanes_t en;
    dbsc_pkg::dbsc_beats_t ex;
    ex = '0;
    wr(19'h00020, '0, '0);
    for (int l = 0; l < 4; l++) begin
      en = '1;
      en[0][l] = 1'b0;
      en[1][3-l] = 1'b0;
      ex[0][l*9 +: 9] = 9'h1FF;
      ex[1][(3-l)*9 +: 9] = 9'h1FF;
      wr(19'h00020, '1, en);
      rd(19'h00020, ex);
    end
    wr(19'h00020, '0, '1);
    rd(19'h00020, ex);
  endtask : s_lanes

  // load select high with read select flipping is no operation
  task automatic s_nop;
    for (int i = 0; i < 3; i++) begin
      i_dbsc_ctrl_model.idle();
      chk_q(1'b0, '0);
    end
  endtask : s_nop

  // clocks stop only after the read has completed; outputs must hold
  task automatic s_stop;
    i_dbsc_ctrl_model.issue(1'b1, 19'h00010, '0, '1);
    i_dbsc_ctrl_model.idle();
    i_dbsc_ctrl_model.idle();
    #1;
    clk_run = 1'b0;
    #60;
    `CHK(dq_oe, 1'b1)
    `CHK(dq_out, {E0, D1})
    clk_run = 1'b1;
    @(posedge clock);
    chk_q(1'b0, '0);
  endtask : s_stop

  // delay loop bypassed: data one cycle after the read command
  task automatic s_bypass;
    dll_disable_n <= 1'b0;
    repeat (6) @(posedge clock);
    i_dbsc_ctrl_model.issue(1'b1, 19'h00013, '0, '1);
    i_dbsc_ctrl_model.idle();
    chk_q(1'b1, {D1, D0});
    chk_q(1'b0, '0);
    dll_disable_n <= 1'b1;
    repeat (6) @(posedge clock);
  endtask : s_bypass

  // watchdog far beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    errors++;
    wrap_up();
  end

  initial begin
    clk_run = 1'b1;
    rst = 1'b1;
    dll_disable_n = 1'b1;
    repeat (5) @(posedge clock);
    #1;
    `CHK(dq_oe, 1'b0)
    `CHK(dq_out, '0)
    `CHK(write_ready, 1'b1)
    @(posedge clock);
    rst <= 1'b0;
    s_burst();
    s_lanes();
    s_nop();
    s_stop();
    s_bypass();
    rd(19'h00013, {D1, D0});
    `CHK(write_ready, 1'b1)
    wrap_up();
  end
endmodule : dbsc_port_test

// File: verilog/dbsc_array.sv
// two-port storage array, one port per burst beat, registered read data
`timescale 1ns/1ns
module dbsc_array #(
  parameter int AW = 19,
  parameter int DW = 36,
  parameter int LANES = 4,
  parameter int LANE_W = 9
) (
  input wire logic clk,
  input wire logic [1:0][AW-1:0] addr,
  input wire logic [1:0] wr,
  input wire logic [1:0][LANES-1:0] lane_en,
  input wire logic [1:0][DW-1:0] wdata,
  output logic [1:0][DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // each port either writes its enabled lanes or reads a whole word
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (wr[p]) begin
        for (int l = 0; l < LANES; l++) begin
          if (lane_en[p][l]) begin
            mem[addr[p]][l*LANE_W +: LANE_W] <= wdata[p][l*LANE_W +: LANE_W];
          end
        end
      end else begin
        rdata[p] <= mem[addr[p]];
      end
    end
  end

endmodule : dbsc_array

// File: verilog/dbsc_fifo.sv
// write buffer fifo with valid/ready on both sides
`timescale 1ns/1ns
module dbsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  // full and empty come straight from the occupancy count
  assign in_ready = (count_reg != FULL_COUNT);
  assign out_valid = (count_reg != '0);
  assign out_data = store[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage has no reset; only pointers and the count carry control state
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_ptr_reg] <= in_data;
    end
  end

  // depth is a power of two so pointers wrap on their own
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
    (count_reg == FULL_COUNT && !pop) |=> (count_reg == FULL_COUNT))
    else $error("fifo lost an entry while full");

endmodule : dbsc_fifo

// File: verilog/dbsc_pkg.sv
// shared widths, reset values and carrier types of the burst-of-two port
package dbsc_pkg;

  localparam int DATA_W = 36;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int ADDR_W = 19;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_STAGES = 3;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [SYNC_STAGES-1:0] SYNC_RESET = 3'h7;

  // beat 0 is the first beat of the burst, beat 1 the second
  typedef logic [1:0][DATA_W-1:0] dbsc_beats_t;
  typedef logic [1:0][LANES-1:0] dbsc_lanes_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } dbsc_cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    dbsc_lanes_t en;
    dbsc_beats_t data;
  } dbsc_wr_t;

  localparam dbsc_cmd_t CMD_IDLE = '0;
  localparam dbsc_wr_t WR_IDLE = '0;

  // two-bit linear burst counter: only the low two address bits advance
  function automatic logic [ADDR_W-1:0] dbsc_burst_next(
    input logic [ADDR_W-1:0] a
  );
    return {a[ADDR_W-1:2], a[1:0] + BURST_STEP};
  endfunction : dbsc_burst_next

endpackage : dbsc_pkg

// File: verilog/dbsc_port.sv
// command and data port of a ddr burst-of-two common-io sram
//
// Overview of operation
// [RULE_01] Second beat address comes from a two-bit linear counter: base plus one.
// [RULE_02] Load select low with read/write select high starts a burst read.
// [RULE_03] Load select low with read/write select low starts a burst write.
// [RULE_04] Address and command are taken only when load select is sampled low.
// [RULE_05] Load select high is a no-op: select ignored, data pins left undriven.
// [RULE_06] Pending bursts finish before clock stop; outputs hold their state.
// [RULE_07] Read data appear two cycles after the read command.
// [RULE_08] Controller issues the write and supplies its beats one cycle later.
// [RULE_09] Narrow mode: enables 0 and 1 gate bits 0-8, 9-17; none aborts.
// [RULE_10] Wide mode: four enables gate four 9-bit lanes; none aborts.
// [RULE_11] Byte enables of each beat are taken together with that beat's data.
// [RULE_12] Write data follow one cycle after the write address.
// [RULE_13] Reads to the last two write addresses return the buffered data.
// [RULE_14] With the delay loop disabled, read latency is one cycle.
// [RULE_15] Address is presented on the same edge as the load select.
//
// both beats of a burst travel side by side in one clock cycle; the
// half-cycle beat positions of the pins map onto beat 0 and beat 1.
`timescale 1ns/1ns
module dbsc_port #(
  parameter bit WIDE = 1'b1,
  parameter int FIFO_DEPTH = dbsc_pkg::FIFO_DEPTH
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic LOAD_SELECT_N,
  input wire logic RW_SELECT,
  input wire logic [dbsc_pkg::ADDR_W-1:0] ADDR,
  input wire dbsc_pkg::dbsc_beats_t DQ_IN,
  input wire dbsc_pkg::dbsc_lanes_t BYTE_ENABLE_N,
  input wire logic DLL_DISABLE_N,
  output dbsc_pkg::dbsc_beats_t DQ_OUT,
  output logic DQ_OE,
  output logic WRITE_READY
);
  localparam int AW = dbsc_pkg::ADDR_W;
  localparam int LANES = dbsc_pkg::LANES;
  localparam int LW = dbsc_pkg::LANE_W;
  localparam int WR_W = $bits(dbsc_pkg::dbsc_wr_t);
  // narrow mode has only the two low lanes
  localparam logic [LANES-1:0] LANE_ON =
    WIDE ? {LANES{1'b1}} : {{(LANES-2){1'b0}}, 2'h3};

  dbsc_pkg::dbsc_cmd_t cmd_reg;
  dbsc_pkg::dbsc_cmd_t cmd_next;
  logic [dbsc_pkg::SYNC_STAGES-1:0] dll_sync_reg;
  logic dll_off_reg;
  logic rd_issue;
  logic wr_data_cyc;
  dbsc_pkg::dbsc_lanes_t wr_en;
  dbsc_pkg::dbsc_wr_t push_entry;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WR_W-1:0] fifo_out_data;
  dbsc_pkg::dbsc_wr_t head;
  logic drain;
  logic [1:0][AW-1:0] mem_addr;
  dbsc_pkg::dbsc_beats_t mem_rdata;
  dbsc_pkg::dbsc_wr_t hist_reg [2];
  logic [1:0] hist_vld_reg;
  logic rd_pipe_reg;
  logic [AW-1:0] rd_addr_pipe_reg;
  dbsc_pkg::dbsc_beats_t fwd_data;
  dbsc_pkg::dbsc_beats_t out_reg;
  logic oe_reg;

  // the bypass strap is a free pin: three flops, change taken once the
  // last two agree, so a glitch cannot flip the read latency mid-burst
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      dll_sync_reg <= dbsc_pkg::SYNC_RESET;
    end else begin
      dll_sync_reg <= {dll_sync_reg[1:0], DLL_DISABLE_N};
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      dll_off_reg <= 1'b0;
    end else if (dll_sync_reg[1] == dll_sync_reg[2]) begin
      dll_off_reg <= ~dll_sync_reg[2]; // [RULE_14]
    end
  end

  // command register: address follows only a loaded command, so a no-op
  // leaves the last address and the read/write select is ignored
  always_comb begin
    cmd_next.valid = !LOAD_SELECT_N; // [RULE_04] [RULE_05]
    cmd_next.write = !RW_SELECT; // [RULE_02] [RULE_03]
    cmd_next.addr = LOAD_SELECT_N ? cmd_reg.addr : ADDR; // [RULE_15]
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cmd_reg <= dbsc_pkg::CMD_IDLE;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  assign rd_issue = cmd_reg.valid && !cmd_reg.write; // [RULE_02]
  assign wr_data_cyc = cmd_reg.valid && cmd_reg.write; // [RULE_03]

  // late write: beats and their enables arrive the cycle after the command
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      wr_en[b] = ~BYTE_ENABLE_N[b] & LANE_ON; // [RULE_09] [RULE_10] [RULE_11]
    end
    push_entry.addr = cmd_reg.addr;
    push_entry.en = wr_en;
    push_entry.data = DQ_IN; // [RULE_08] [RULE_12]
  end

  // a burst with no lane enabled on either beat is aborted outright
  assign fifo_in_valid = wr_data_cyc && (|wr_en); // [RULE_09] [RULE_10]
  assign WRITE_READY = fifo_in_ready;

  dbsc_fifo #(
    .WIDTH(WR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(CLOCK),
    .rst(RST),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_entry),
    .out_valid(fifo_out_valid),
    .out_ready(!rd_issue),
    .out_data(fifo_out_data)
  );

  // reads own the array slot; writes drain in the gaps between reads,
  // trading write-back delay for a fixed read latency
  assign head = dbsc_pkg::dbsc_wr_t'(fifo_out_data);
  assign drain = fifo_out_valid && !rd_issue;

  always_comb begin
    mem_addr[0] = rd_issue ? cmd_reg.addr : head.addr;
    mem_addr[1] = dbsc_pkg::dbsc_burst_next(mem_addr[0]); // [RULE_01]
  end

  dbsc_array #(
    .AW(AW),
    .DW(dbsc_pkg::DATA_W),
    .LANES(LANES),
    .LANE_W(LW)
  ) u_array (
    .clk(CLOCK),
    .addr(mem_addr),
    .wr({drain, drain}),
    .lane_en(head.en),
    .wdata(head.data),
    .rdata(mem_rdata)
  );

  // the two newest accepted writes, newest in slot 0
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      hist_reg[0] <= dbsc_pkg::WR_IDLE;
      hist_reg[1] <= dbsc_pkg::WR_IDLE;
      hist_vld_reg <= 2'h0;
    end else if (fifo_in_valid && fifo_in_ready) begin
      hist_reg[1] <= hist_reg[0];
      hist_reg[0] <= push_entry;
      hist_vld_reg <= {hist_vld_reg[0], 1'b1};
    end
  end

  // read pipeline: address of the burst waits beside the array access
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rd_pipe_reg <= 1'b0;
      rd_addr_pipe_reg <= '0;
    end else begin
      rd_pipe_reg <= rd_issue;
      if (rd_issue) begin
        rd_addr_pipe_reg <= cmd_reg.addr;
      end
    end
  end

  // coherency: overlay the two newest writes, older first, lane by lane
  always_comb begin
    logic [AW-1:0] rd_a;
    logic [AW-1:0] wr_a;
    rd_a = '0;
    wr_a = '0;
    fwd_data = mem_rdata;
    for (int k = 1; k >= 0; k--) begin
      for (int b = 0; b < 2; b++) begin
        rd_a = (b == 0) ? rd_addr_pipe_reg
                        : dbsc_pkg::dbsc_burst_next(rd_addr_pipe_reg);
        for (int j = 0; j < 2; j++) begin
          wr_a = (j == 0) ? hist_reg[k].addr
                          : dbsc_pkg::dbsc_burst_next(hist_reg[k].addr);
          for (int l = 0; l < LANES; l++) begin
            if (hist_vld_reg[k] && wr_a == rd_a && hist_reg[k].en[j][l]) begin
              fwd_data[b][l*LW +: LW] = hist_reg[k].data[j][l*LW +: LW]; // [RULE_13]
            end
          end
        end
      end
    end
  end

  // output register: data hold after a burst, so a stopped clock leaves
  // the pins at their previous state
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      out_reg <= '0;
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= rd_pipe_reg; // [RULE_05] [RULE_07]
      if (rd_pipe_reg) begin
        out_reg <= fwd_data; // [RULE_06]
      end
    end
  end

  // bypass mode skips the output register, one cycle earlier
  assign DQ_OUT = dll_off_reg ? fwd_data : out_reg; // [RULE_14]
  assign DQ_OE = dll_off_reg ? rd_pipe_reg : oe_reg; // [RULE_07] [RULE_14]

  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  cmd_taken_a: assert property ( // [RULE_04]
    !LOAD_SELECT_N |=> (cmd_reg.valid && cmd_reg.addr == $past(ADDR)))
    else $error("loaded command not registered");

  nop_high_z_a: assert property ( // [RULE_05]
    (LOAD_SELECT_N && !dll_off_reg) |-> ##3 (!DQ_OE || dll_off_reg))
    else $error("data driven after a no-op");

  read_latency_a: assert property ( // [RULE_07]
    (!LOAD_SELECT_N && RW_SELECT && !dll_off_reg)
      |-> ##3 (DQ_OE || dll_off_reg))
    else $error("read data not driven two cycles after command");

  bypass_latency_a: assert property ( // [RULE_14]
    (!LOAD_SELECT_N && RW_SELECT && dll_off_reg)
      |-> ##2 (DQ_OE || !dll_off_reg))
    else $error("bypass read data not one cycle after command");

  burst_addr_a: assert property ( // [RULE_01]
    rd_issue |-> (mem_addr[0] == cmd_reg.addr &&
      mem_addr[1][1:0] == cmd_reg.addr[1:0] + 2'h1 &&
      mem_addr[1][AW-1:2] == cmd_reg.addr[AW-1:2]))
    else $error("second burst address is not base plus one");

  write_capture_a: assert property ( // [RULE_03]
    (wr_data_cyc && (|wr_en) && fifo_in_ready)
      |=> (hist_reg[0].addr == $past(cmd_reg.addr) &&
           hist_reg[0].data == $past(DQ_IN)))
    else $error("write burst not captured the cycle after command");

  write_abort_a: assert property ( // [RULE_09] [RULE_10]
    (wr_data_cyc && (&BYTE_ENABLE_N[0]) && (&BYTE_ENABLE_N[1]))
      |=> $stable(hist_vld_reg) && hist_reg[0] == $past(hist_reg[0]))
    else $error("aborted write was buffered");

  coherent_read_a: assert property ( // [RULE_13]
    (rd_pipe_reg && hist_vld_reg[0] && hist_reg[0].addr == rd_addr_pipe_reg
      && hist_reg[0].en[0] == LANE_ON)
      |-> (fwd_data[0] == hist_reg[0].data[0]))
    else $error("read ignored the newest buffered write");

endmodule : dbsc_port
